/* ecl_pkg.sv */
// Constants, field layouts and carrier types for the configuration word loader
package ecl_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;                       // clk_sys at 25 MHz
  localparam int SCK_HALF_NS   = 80;                       // Least serial clock half period
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // Serial memory layout
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  MEM_RD_CMD   = 8'h03;            // Read opcode sent before address
  localparam logic [7:0]  MEM_ADR_SIG  = 8'h00;            // Signature word
  localparam logic [7:0]  MEM_ADR_W06  = 8'h06;            // Capability and switch mode word
  localparam logic [7:0]  MEM_ADR_W0C  = 8'h0C;            // Payload, power and disable word
  localparam logic [2:0]  WORD_LAST    = 3'h6;             // Index of word at address 0Ch
  localparam logic [15:0] SIG_DEFAULT  = 16'hA55A;         // Arbitrary value, not a real part

  // Source bit positions in word 06h
  localparam int W06_VC      = 0;
  localparam int W06_L0S_LSB = 1;
  localparam int W06_L1_LSB  = 4;
  localparam int W06_NOEG    = 8;
  localparam int W06_NOTAG   = 9;
  localparam int W06_SNF     = 10;
  localparam int W06_CT_LSB  = 11;
  localparam int W06_ARB     = 13;
  localparam int W06_CRED    = 14;
  localparam int W06_INTA    = 15;
  // Source bit positions in word 0Ch
  localparam int W0C_MPS_LSB  = 0;
  localparam int W0C_ASPM_LSB = 2;
  localparam int W0C_RBER     = 4;
  localparam int W0C_MSI      = 5;
  localparam int W0C_CPAR     = 6;

  // ---------------------------------------------------------------------------
  // Configuration space offsets (byte addresses) and bit positions
  // ---------------------------------------------------------------------------
  localparam logic [11:0] OFS_3C   = 12'h03C;
  localparam logic [11:0] OFS_70   = 12'h070;
  localparam logic [11:0] OFS_74   = 12'h074;
  localparam logic [11:0] OFS_C4   = 12'h0C4;
  localparam logic [11:0] OFS_CC   = 12'h0CC;
  localparam logic [11:0] OFS_144  = 12'h144;
  localparam logic [11:0] OFS_CTRL = 12'h200;              // Loader control
  localparam logic [11:0] OFS_STAT = 12'h204;              // Loader status
  localparam logic [11:0] OFS_RAW  = 12'h240;              // Raw word window, 8 words

  localparam int D144_VC     = 0;
  localparam int DCC_ASPM    = 10;
  localparam int DCC_L0S     = 12;
  localparam int DCC_L1      = 15;
  localparam int D74_SNF     = 0;
  localparam int D74_CT      = 1;
  localparam int D74_ARB     = 3;
  localparam int D74_CRED    = 4;
  localparam int D74_NOEG    = 5;
  localparam int D74_NOTAG   = 6;
  localparam int D74_CPAR    = 15;
  localparam int D3C_INTA    = 8;
  localparam int DC4_MPS     = 0;
  localparam int DC4_RBER    = 15;
  localparam int D70_MSI     = 14;
  localparam int CTRL_RELOAD = 0;
  localparam int CTRL_PSEL   = 1;                          // Two bits: port shown in readback

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       vc_ext;      // Extra virtual channel count
    logic [2:0] l0s_lat;     // L0s exit latency
    logic [2:0] l1_lat;      // L1 exit latency
    logic       no_ord_eg;   // No ordering across egress ports
    logic       no_ord_tag;  // No ordering across completion tags
    logic       store_fwd;   // Store and forward
    logic [1:0] ct_thresh;   // Cut-through threshold
    logic       arb_mode;    // Port arbiter mode
    logic       cred_mode;   // Credit update mode
    logic       inta_req;    // Interrupt pin A requested
    logic [1:0] max_pay;     // Max payload size supported
    logic [1:0] aspm_sup;    // ASPM support level
    logic       rber;        // Role-based error reporting
    logic       msi_dis;     // MSI capability removed
    logic       cpar_dis;    // Compliance pattern parity off
  } ecl_cfg_t;

  localparam ecl_cfg_t CFG_RST = '0;                       // Hardware defaults

  typedef enum logic [2:0] {ST_ISSUE, ST_WAIT, ST_APPLY, ST_DONE} ecl_state_t;

endpackage : ecl_pkg

/* ecl_word_mem.sv */
// Small dual-port store of raw configuration words with registered read data
module ecl_word_mem
  import ecl_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk_sys,  // System clock
  input  wire logic             wr_en,    // Write strobe
  input  wire logic [AW-1:0]    wr_adr,   // Write index
  input  wire logic [WIDTH-1:0] wr_dat,   // Write data
  input  wire logic [AW-1:0]    rd_adr,   // Read index
  output logic      [WIDTH-1:0] rd_dat_q  // Read data, one cycle after address
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage write; no reset so it maps onto memory cells
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_adr] <= wr_dat;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys) begin
    rd_dat_q <= mem[rd_adr];
  end

endmodule : ecl_word_mem

/* ecl_serial_rd.sv */
// Serial memory reader: one 16-bit word per request over a four-wire link
module ecl_serial_rd
  import ecl_pkg::*;
(
  input  wire logic        clk_sys,    // System clock
  input  wire logic        reset,      // Asynchronous reset, active high
  input  wire logic        start,      // Pulse: read word at adr
  input  wire logic [7:0]  adr,        // Byte address of word
  input  wire logic        mem_miso,   // Data from memory
  output logic             mem_cs_n_q, // Chip select, active low
  output logic             mem_sck_q,  // Serial clock
  output logic             mem_mosi_q, // Data to memory
  output logic             done_q,     // Pulse: word ready
  output logic [15:0]      word_q      // Word read
);

  localparam int DIVW = $clog2(SCK_HALF_CYC + 1);
  localparam logic [DIVW-1:0] DIV_END = DIVW'(SCK_HALF_CYC - 1);
  localparam logic [4:0] BIT_LAST = 5'h1F;                // 16 out, 16 in
  localparam logic [4:0] BIT_IN   = 5'h10;

  logic            busy_q;
  logic [DIVW-1:0] div_q;
  logic [4:0]      bit_q;
  logic [15:0]     sh_out_q;
  logic [15:0]     sh_in_q;

  // Shift engine: data changes while clock low, sampled on the rising edge
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0; div_q <= '0; bit_q <= '0; sh_out_q <= '0; sh_in_q <= '0;
      mem_cs_n_q <= 1'b1; mem_sck_q <= 1'b0; mem_mosi_q <= 1'b0;
      done_q <= 1'b0; word_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q && start) begin
        busy_q     <= 1'b1;
        mem_cs_n_q <= 1'b0;
        sh_out_q   <= {MEM_RD_CMD[6:0], adr, 1'b0};
        mem_mosi_q <= MEM_RD_CMD[7];
        bit_q      <= '0;
        div_q      <= '0;
      end else if (busy_q) begin
        if (div_q != DIV_END) begin
          div_q <= div_q + 1'b1;
        end else begin
          div_q     <= '0;
          mem_sck_q <= ~mem_sck_q;
          if (!mem_sck_q && bit_q >= BIT_IN) begin
            sh_in_q <= {sh_in_q[14:0], mem_miso};
          end
          if (mem_sck_q) begin
            if (bit_q == BIT_LAST) begin
              busy_q     <= 1'b0;
              mem_cs_n_q <= 1'b1;
              done_q     <= 1'b1;
              word_q     <= sh_in_q;
            end else begin
              bit_q      <= bit_q + 1'b1;
              mem_mosi_q <= sh_out_q[15];
              sh_out_q   <= {sh_out_q[14:0], 1'b0};
            end
          end
        end
      end
    end
  end

endmodule : ecl_serial_rd

/* ecl_loader.sv */
// Configuration word loader: reads setup words and scatters them into port fields
//
// The address map and the Wishbone interface to the registers were decided locally.
module ecl_loader
  import ecl_pkg::*;
#(
  parameter int          NPORT = 3,
  parameter logic [15:0] SIG   = SIG_DEFAULT    // Arbitrary signature value
) (
  input  wire logic        clk_sys,             // System clock
  input  wire logic        reset,               // Asynchronous reset, active high
  input  wire logic        wb_cyc,              // Wishbone cycle
  input  wire logic        wb_stb,              // Wishbone strobe
  input  wire logic        wb_we,               // Wishbone write enable
  input  wire logic [11:0] wb_adr,              // Wishbone byte address
  input  wire logic [3:0]  wb_sel,              // Wishbone byte lanes
  input  wire logic [31:0] wb_dat_w,            // Wishbone write data
  output logic      [31:0] wb_dat_r,            // Wishbone read data
  output logic             wb_ack,              // Wishbone acknowledge
  input  wire logic        mem_miso,            // Serial memory data in
  output logic             mem_cs_n,            // Serial memory select
  output logic             mem_sck,             // Serial memory clock
  output logic             mem_mosi,            // Serial memory data out
  output logic             ports_hold_q,        // Ports refuse config requests
  output ecl_cfg_t         port_cfg_q [NPORT]   // Loaded fields per port
);

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------
  // Scatter the two setup words into one port's fields
  function automatic ecl_cfg_t cfg_decode(input logic [15:0] w06, input logic [15:0] w0c,
                                          input bit has_int);
    ecl_cfg_t c;
    c            = CFG_RST;
    c.vc_ext     = w06[W06_VC];
    c.l0s_lat    = w06[W06_L0S_LSB +: 3];
    c.l1_lat     = w06[W06_L1_LSB +: 3];
    c.no_ord_eg  = w06[W06_NOEG];
    c.no_ord_tag = w06[W06_NOTAG];
    c.store_fwd  = w06[W06_SNF];
    c.ct_thresh  = w06[W06_CT_LSB +: 2];
    c.arb_mode   = w06[W06_ARB];
    c.cred_mode  = w06[W06_CRED];
    c.inta_req   = has_int ? w06[W06_INTA] : 1'b0;
    c.max_pay    = w0c[W0C_MPS_LSB +: 2];
    c.aspm_sup   = w0c[W0C_ASPM_LSB +: 2];
    c.rber       = w0c[W0C_RBER];
    c.msi_dis    = w0c[W0C_MSI];
    c.cpar_dis   = w0c[W0C_CPAR];
    return c;
  endfunction : cfg_decode

  // Place fields at their configuration offset; other offsets read zero
  function automatic logic [31:0] cfg_image(input ecl_cfg_t c, input logic [11:0] ofs);
    logic [31:0] r;
    r = '0;
    case (ofs)
      OFS_144: r[D144_VC] = c.vc_ext;
      OFS_CC: begin
        r[DCC_ASPM +: 2] = c.aspm_sup;
        r[DCC_L0S +: 3]  = c.l0s_lat;
        r[DCC_L1 +: 3]   = c.l1_lat;
      end
      OFS_74: begin
        r[D74_SNF]    = c.store_fwd;
        r[D74_CT +: 2] = c.ct_thresh;
        r[D74_ARB]    = c.arb_mode;
        r[D74_CRED]   = c.cred_mode;
        r[D74_NOEG]   = c.no_ord_eg;
        r[D74_NOTAG]  = c.no_ord_tag;
        r[D74_CPAR]   = c.cpar_dis;
      end
      OFS_3C: r[D3C_INTA] = c.inta_req;
      OFS_C4: begin
        r[DC4_MPS +: 2] = c.max_pay;
        r[DC4_RBER]     = c.rber;
      end
      OFS_70: r[D70_MSI] = c.msi_dis;
      default: r = '0;
    endcase
    return r;
  endfunction : cfg_image

  // ---------------------------------------------------------------------------
  // Loader sequence
  // ---------------------------------------------------------------------------
  ecl_state_t  state_q;
  logic [2:0]  idx_q;
  logic        rd_start_q;
  logic        sig_ok_q;
  logic        sig_bad_q;
  logic [15:0] w06_q;
  logic [15:0] w0c_q;
  logic        rd_done;
  logic [15:0] rd_word;
  logic        reload_q;
  logic [1:0]  psel_q;

  ecl_serial_rd u_rd (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .start      (rd_start_q),
    .adr        ({4'h0, idx_q, 1'b0}),
    .mem_miso   (mem_miso),
    .mem_cs_n_q (mem_cs_n),
    .mem_sck_q  (mem_sck),
    .mem_mosi_q (mem_mosi),
    .done_q     (rd_done),
    .word_q     (rd_word)
  );

  // Word sequencing; a reload is honoured only while in ST_DONE and dropped otherwise, so no read is orphaned
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q    <= ST_ISSUE;
      idx_q      <= '0;
      rd_start_q <= 1'b0;
      sig_ok_q   <= 1'b0;
      sig_bad_q  <= 1'b0;
      w06_q      <= '0;
      w0c_q      <= '0;
    end else begin
      rd_start_q <= 1'b0;
      case (state_q)
        ST_ISSUE: begin
          rd_start_q <= 1'b1;
          state_q    <= ST_WAIT;
        end
        ST_WAIT: begin
          if (rd_done) begin
            if ({idx_q, 1'b0} == 4'(MEM_ADR_W06)) w06_q <= rd_word;
            if ({idx_q, 1'b0} == 4'(MEM_ADR_W0C)) w0c_q <= rd_word;
            if ({idx_q, 1'b0} == 4'(MEM_ADR_SIG) && rd_word != SIG) begin
              sig_bad_q <= 1'b1;
              state_q   <= ST_DONE;
            end else if (idx_q == WORD_LAST) begin
              sig_ok_q <= 1'b1;
              state_q  <= ST_APPLY;
            end else begin
              idx_q   <= idx_q + 1'b1;
              state_q <= ST_ISSUE;
            end
          end
        end
        ST_APPLY: state_q <= ST_DONE;
        ST_DONE: begin
          if (reload_q) begin
            idx_q     <= '0;
            sig_ok_q  <= 1'b0;
            sig_bad_q <= 1'b0;
            state_q   <= ST_ISSUE;
          end
        end
        default: state_q <= ST_DONE;
      endcase
    end
  end

  // Port fields: cleared on reload and loaded only in the apply step, so a bad signature keeps defaults
  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_port
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          port_cfg_q[p] <= CFG_RST;
        end else if (state_q == ST_DONE && reload_q) begin
          port_cfg_q[p] <= CFG_RST;
        end else if (state_q == ST_APPLY) begin
          port_cfg_q[p] <= cfg_decode(w06_q, w0c_q, p != 0);
        end
      end
    end
  endgenerate

  // Hold lifts one cycle after the fields settle, never while loading
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ports_hold_q <= 1'b1;
    end else begin
      ports_hold_q <= (state_q != ST_DONE) || reload_q;
    end
  end

  // Raw word store for software inspection
  logic [31:0] raw_q;
  logic [15:0] raw_rd;

  ecl_word_mem #(.WIDTH(16), .DEPTH(8)) u_mem (
    .clk_sys  (clk_sys),
    .wr_en    (state_q == ST_WAIT && rd_done),
    .wr_adr   (idx_q),
    .wr_dat   (rd_word),
    .rd_adr   (wb_adr[4:2]),
    .rd_dat_q (raw_rd)
  );
  assign raw_q = {16'h0000, raw_rd};

  // ---------------------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------------------
  logic        pend_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        wr_ctrl;
  logic        in_raw;
  logic [31:0] cfg_rd;

  assign wb_ack   = ack_q;
  assign wb_dat_r = dat_q;
  assign wr_ctrl  = pend_q && wb_we && wb_adr == OFS_CTRL && wb_sel[0];
  assign in_raw   = wb_adr[11:5] == OFS_RAW[11:5];
  assign cfg_rd   = (psel_q < 2'(NPORT)) ? cfg_image(port_cfg_q[psel_q], wb_adr) : '0;

  // Two-stage answer: the second cycle lets the raw store's read register fill
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pend_q <= 1'b0;
      ack_q  <= 1'b0;
      dat_q  <= '0;
    end else begin
      ack_q  <= 1'b0;
      pend_q <= 1'b0;
      if (wb_cyc && wb_stb && !pend_q && !ack_q) begin
        pend_q <= 1'b1;
      end
      if (pend_q) begin
        ack_q <= 1'b1;
        dat_q <= '0;
        if (!wb_we) begin
          if (wb_adr == OFS_CTRL) dat_q <= {29'h0, psel_q, 1'b0};
          else if (wb_adr == OFS_STAT)
            dat_q <= {28'h0, sig_bad_q, sig_ok_q, ports_hold_q, state_q == ST_DONE};
          else if (in_raw) dat_q <= raw_q;
          else dat_q <= cfg_rd;
        end
      end
    end
  end

  // Control: port select for readback and a self-clearing reload pulse
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reload_q <= 1'b0;
      psel_q   <= '0;
    end else begin
      reload_q <= 1'b0;
      if (wr_ctrl) begin
        reload_q <= wb_dat_w[CTRL_RELOAD];
        psel_q   <= wb_dat_w[CTRL_PSEL +: 2];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_VC: assert property (state_q == ST_APPLY |=>
    port_cfg_q[0].vc_ext == $past(w06_q[W06_VC]) && port_cfg_q[2].vc_ext == w06_q[W06_VC])
    else $error("extended VC count not loaded");
  AST_L0S: assert property (state_q == ST_APPLY |=>
    port_cfg_q[1].l0s_lat == w06_q[W06_L0S_LSB +: 3])
    else $error("L0s latency not loaded");
  AST_L1: assert property (state_q == ST_APPLY |=>
    port_cfg_q[2].l1_lat == w06_q[W06_L1_LSB +: 3])
    else $error("L1 latency not loaded");
  AST_SWMODE: assert property (state_q == ST_APPLY |=>
    {port_cfg_q[0].store_fwd, port_cfg_q[0].no_ord_tag, port_cfg_q[0].no_ord_eg}
      == w06_q[W06_NOEG +: 3])
    else $error("switch ordering modes not loaded");
  AST_ARB: assert property (state_q == ST_APPLY |=>
    {port_cfg_q[1].cred_mode, port_cfg_q[1].arb_mode, port_cfg_q[1].ct_thresh}
      == w06_q[W06_CT_LSB +: 4])
    else $error("threshold, arbiter or credit mode not loaded");
  AST_INTPIN: assert property (state_q == ST_APPLY |=>
    !port_cfg_q[0].inta_req && port_cfg_q[1].inta_req == w06_q[W06_INTA])
    else $error("interrupt pin bit wrong");
  AST_W0C: assert property (state_q == ST_APPLY |=>
    {port_cfg_q[2].cpar_dis, port_cfg_q[2].msi_dis, port_cfg_q[2].rber,
     port_cfg_q[2].aspm_sup, port_cfg_q[2].max_pay} == w0c_q[6:0])
    else $error("word 0Ch fields not loaded");
  AST_NO_APPLY: assert property (sig_bad_q |-> port_cfg_q[1] == CFG_RST)
    else $error("fields changed after bad signature");
  AST_SIG_STOP: assert property (state_q == ST_WAIT && rd_done && idx_q == 3'h0
    && rd_word != SIG |=> state_q == ST_DONE ##1 !ports_hold_q)
    else $error("bad signature did not end the load");
  AST_HOLD: assert property (state_q != ST_DONE |=> ports_hold_q)
    else $error("ports released during load");
  AST_RELEASE: assert property (state_q == ST_APPLY |=>
    ports_hold_q ##1 !ports_hold_q)
    else $error("ports not released after apply");

  COV_LOADED: cover property (state_q == ST_APPLY ##2 !ports_hold_q);
  COV_BADSIG: cover property ($rose(sig_bad_q));
  COV_RELOAD: cover property (reload_q && state_q == ST_DONE ##1 state_q == ST_ISSUE);

endmodule : ecl_loader

/* ecl_mem_model.sv */
// Behavioural serial configuration memory that answers the read opcode
module ecl_mem_model
  import ecl_pkg::*;
(
  input  wire logic        mem_cs_n,  // Select, active low
  input  wire logic        mem_sck,   // Serial clock from loader
  input  wire logic        mem_mosi,  // Opcode and address in
  input  wire logic [15:0] words [8], // Stored words
  output logic             mem_miso   // Data out
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cnt;
  logic [15:0] hdr;
  // Shift opcode and address in on rising clock; a frame restarts on deselect
  always @(posedge mem_sck or posedge mem_cs_n) begin
    if (mem_cs_n) begin
      cnt <= 0;
    end else begin
      if (cnt < 16) hdr <= {hdr[14:0], mem_mosi};
      cnt <= cnt + 1;
    end
  end
  // Data moves on falling clock; outside data bits the line toggles so stale bits show
  initial mem_miso = 1'b0;
  always @(negedge mem_sck or posedge mem_cs_n) begin
    if (mem_cs_n || cnt < 16 || cnt > 31 || hdr[15:8] != MEM_RD_CMD) mem_miso <= ~mem_miso;
    else mem_miso <= words[hdr[3:1]][31-cnt];
  end
endmodule : ecl_mem_model

/* ecl_loader_bench.sv */
// Self-checking bench for the configuration word loader
module ecl_loader_bench;
  import ecl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        reset   = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dw  = 32'h0000_0000;
  logic [31:0] dr, r;
  logic        ack, miso, cs_n, sck, mosi, hold;
  ecl_cfg_t    cfg [3];
  logic [15:0] words [8];
  logic [15:0] seed = 16'h003B;
  int          n_fail = 0;
  int          cmp_count = 0;
  // ---------------------------------------------------------------------------
  // Clock, design and memory
  // ---------------------------------------------------------------------------
  always #20 clk_sys = ~clk_sys;
  ecl_loader #(.NPORT(3), .SIG(SIG_DEFAULT)) u_dut (.clk_sys(clk_sys), .reset(reset),
    .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dw),
    .wb_dat_r(dr), .wb_ack(ack), .mem_miso(miso), .mem_cs_n(cs_n), .mem_sck(sck),
    .mem_mosi(mosi), .ports_hold_q(hold), .port_cfg_q(cfg));
  ecl_mem_model u_mem (.mem_cs_n(cs_n), .mem_sck(sck), .mem_mosi(mosi), .words(words),
    .mem_miso(miso));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Fields expected at one port; port 0 never requests the interrupt pin
  function automatic ecl_cfg_t expf(int p, logic [15:0] a, logic [15:0] c, bit ok);
    return ok ? {a[0], a[3:1], a[6:4], a[8], a[9], a[10], a[12:11], a[13], a[14],
                 a[15] && p != 0, c[1:0], c[3:2], c[4], c[5], c[6]} : '0;
  endfunction : expf
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Classic single cycle; request held until ack is sampled high
  task automatic wb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clk_sys);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; dw <= d;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (ack !== 1'b1 && k < 100);
    if (k >= 100) check("wb ack", 32'h0, 32'h1);
    q = dr;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // Load one image and check fields at the ports and through readback
  task automatic run(bit ok, bit first);
    int k;
    words[0] = ok ? SIG_DEFAULT : ~SIG_DEFAULT;
    if (!first) wb(1'b1, OFS_CTRL, 32'h0000_0001, r);
    @(posedge clk_sys);
    check("hold", 32'(hold), 32'h1);
    k = 0;
    while (hold !== 1'b0 && k < 5000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 5000) check("load timeout", 32'h0, 32'h1);
    for (int p = 0; p < 3; p++) begin
      check("cfg", 32'(cfg[p]), 32'(expf(p, words[3], words[6], ok)));
      wb(1'b1, OFS_CTRL, {29'h0, 2'(p), 1'b0}, r);
      wb(1'b0, OFS_74, 32'h0, r);
      check("sw mode", r, ok ? {16'h0, words[6][6], 8'h0, words[3][9], words[3][8],
            words[3][14], words[3][13], words[3][12:11], words[3][10]} : 32'h0);
      wb(1'b0, OFS_3C, 32'h0, r);
      check("int pin", r, {23'h0, ok && p != 0 && words[3][15], 8'h0});
    end
    // Remaining field offsets, status and raw store, read with the last port selected
    wb(1'b0, OFS_CC, 32'h0, r);
    check("link cap", r, ok ? {14'h0, words[3][6:4], words[3][3:1], words[6][3:2], 10'h0}
          : 32'h0);
    wb(1'b0, OFS_C4, 32'h0, r);
    check("dev cap", r, ok ? {16'h0, words[6][4], 13'h0, words[6][1:0]} : 32'h0);
    wb(1'b0, OFS_70, 32'h0, r);
    check("msi off", r, ok ? {17'h0, words[6][5], 14'h0} : 32'h0);
    wb(1'b0, OFS_144, 32'h0, r);
    check("vc count", r, ok ? {31'h0, words[3][0]} : 32'h0);
    wb(1'b0, OFS_STAT, 32'h0, r);
    check("status", r, {28'h0, !ok, ok, 2'b01});
    wb(1'b0, OFS_RAW, 32'h0, r);
    check("raw word 0", r, {16'h0, words[0]});
    // Port select beyond the last port reads zero
    wb(1'b1, OFS_CTRL, 32'h0000_0006, r);
    wb(1'b0, OFS_74, 32'h0, r);
    check("no port", r, 32'h0);
    wb(1'b0, 12'h100, 32'h0, r);
    check("unmapped", r, 32'h0);
  endtask : run
  // ---------------------------------------------------------------------------
  // Watchdog and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end
  initial begin
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      words[i] = seed;
    end
    words[3] = 16'hFFFF;
    words[6] = 16'hFFFF;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    run(1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      words[3] = seed;
      seed = lfsr(seed);
      words[6] = seed;
      run(i != 2, 1'b0);
    end
    give_verdict();
  end
endmodule : ecl_loader_bench
